// [hdl/sbc_ctrl_consts.vh]
// constants for the control register group of the bus, watchdog and wake block
// assumes inclusion by bare name from files under hdl/
`ifndef SBC_CTRL_CONSTS_VH
`define SBC_CTRL_CONSTS_VH

// register addresses (7-bit frame address)
`define SBC_ADDR_MODE 7'h01
`define SBC_ADDR_WDOG 7'h03
`define SBC_ADDR_BUSA 7'h04
`define SBC_ADDR_BUSB 7'h05
`define SBC_ADDR_WAKA 7'h06
`define SBC_ADDR_WAKB 7'h07
`define SBC_ADDR_W 7

// reset values
`define SBC_RST_WDOG 8'h14
`define SBC_RST_BUSA 8'h20
`define SBC_RST_BUSB 8'h00
`define SBC_RST_WAKA 8'h00
`define SBC_RST_WAKB 8'h01
`define SBC_RST_MODE 2'h0

// writable masks, reserved bits excluded
`define SBC_MASK_BUSA 8'hfb
`define SBC_MASK_BUSB 8'hdb
`define SBC_MASK_WAKA 8'h44
`define SBC_MASK_WAKB 8'h01

// hardware-owned (rwh) field masks; the other writable bits belong to the host only
`define SBC_HW_WDOG 8'h57
`define SBC_HW_BUSA 8'h1b
`define SBC_HW_BUSB 8'hdb
`define SBC_HW_WAKA 8'h04

// watchdog config fields
`define SBC_WD_PAR 7
`define SBC_WD_STOP_OFF 6
`define SBC_WINDOW_TYPE_SEL 5
`define SBC_WD_BUS_WAKE 4
`define SBC_WD_MAX3 3
`define SBC_WD_PER_HI 2
`define SBC_WD_PER_LO 0
`define SBC_WD_PER_RSVD 3'h7

// bus control a fields
`define SBC_BA_FLASH 7
`define SBC_BA_SLOPE 6
`define SBC_BA_TXTO 5
`define SBC_BA_LIN_CH1_MODE_HI 4
`define SBC_BA_LIN_CH1_MODE_LO 3
`define SBC_BA_CAN_HI 1
`define SBC_BA_CAN_LO 0

// bus control b fields
`define SBC_BB_LIN_CH4_MODE_HI 7
`define SBC_BB_LIN_CH4_MODE_LO 6
`define SBC_BB_LIN_CH3_MODE_HI 4
`define SBC_BB_LIN_CH3_MODE_LO 3
`define SBC_BB_LIN_CH2_MODE_HI 1
`define SBC_BB_LIN_CH2_MODE_LO 0

// wake register fields
`define SBC_WA_TIMER 6
`define SBC_WA_STOP_OFF 2
`define SBC_WB_PIN 0

// transceiver mode codes
`define SBC_XCV_OFF 2'h0
`define SBC_XCV_WAKE 2'h1
`define SBC_XCV_RXO 2'h2
`define SBC_XCV_NORM 2'h3

// operating mode codes
`define SBC_MODE_NORMAL 2'h0
`define SBC_MODE_SLEEP 2'h1
`define SBC_MODE_STOP 2'h2
`define SBC_MODE_SOFT 2'h3
`define SBC_MODE_HI 7
`define SBC_MODE_LO 6

// watchdog period codes
`define SBC_PER_10 3'h0
`define SBC_PER_20 3'h1
`define SBC_PER_50 3'h2
`define SBC_PER_100 3'h3
`define SBC_PER_200 3'h4
`define SBC_PER_500 3'h5

// periods in ms, and cycles per ms at the 10 MHz clock
`define SBC_CLK_KHZ 16'h2710
`define SBC_MS_10 16'h000a
`define SBC_MS_20 16'h0014
`define SBC_MS_50 16'h0032
`define SBC_MS_100 16'h0064
`define SBC_MS_200 16'h00c8
`define SBC_MS_500 16'h01f4

`define SBC_NUM_XCV 5
`endif

// [hdl/sbc_xcv_mode.v]
// one transceiver effective-mode stage: turns the stored mode into the active one
// assumes the operating mode comes from the register bank in the same clock domain
`timescale 1ns/1ns
`default_nettype none
`include "sbc_ctrl_consts.vh"

module sbc_xcv_mode (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // stored mode and chip mode
  input wire [1:0] stored_mode,
  input wire low_power,
  // active mode
  output reg [1:0] active_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // normal is demoted to wake capable in stop or sleep; the stored field is untouched
  always @(posedge ref_clk) begin
    if (!nrst) begin
      active_mode <= `SBC_XCV_OFF;
    end else if (low_power && stored_mode == `SBC_XCV_NORM) begin
      active_mode <= `SBC_XCV_WAKE;
    end else begin
      active_mode <= stored_mode;
    end
  end

endmodule // sbc_xcv_mode
`default_nettype wire

// [hdl/sbc_ctrl_regs.v]
// control register group: watchdog config, bus transceiver modes, wake sources
// assumes a decoded spi frame arrives as a one-cycle strobe with address and data
`timescale 1ns/1ns
`default_nettype none
`include "sbc_ctrl_consts.vh"

module sbc_ctrl_regs (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // decoded spi frame
  input wire frame_valid,
  input wire frame_write,
  input wire [6:0] frame_addr,
  input wire [7:0] frame_data,
  output reg [7:0] read_data,
  output reg read_hit,
  output reg spi_fail,
  // hardware updates of rwh fields
  input wire hw_upd_valid,
  input wire [7:0] hw_upd_wdog,
  input wire [7:0] hw_upd_busa,
  input wire [7:0] hw_upd_busb,
  input wire [7:0] hw_upd_waka,
  // mode control (soft reset restores defaults)
  input wire soft_reset,
  output reg [1:0] chip_mode,
  output reg restart_req,
  output reg reset_out,
  // watchdog controls
  output reg wdog_stop_off,
  output reg window_type_sel,
  output reg wdog_start_on_bus_wake,
  output reg wdog_max3_limit,
  output reg [2:0] wdog_period_sel,
  output reg [15:0] wdog_period_ms,
  output reg [22:0] wdog_period_cycles,
  // lin common controls
  output reg lin_slope_off,
  output reg lin_slope_sel,
  output reg lin_tx_timeout_en,
  // active transceiver modes: can, lin_ch1_mode..lin_ch4_mode
  output wire [1:0] can_mode,
  output wire [1:0] lin_ch1_mode,
  output wire [1:0] lin_ch2_mode,
  output wire [1:0] lin_ch3_mode,
  output wire [1:0] lin_ch4_mode,
  // wake sources
  output reg periodic_timer_wake_en,
  output reg hv_pin_wake_en
);

  reg [7:0] wdog_reg;
  reg [7:0] busa_reg;
  reg [7:0] busb_reg;
  reg [7:0] waka_reg;
  reg [7:0] wakb_reg;
  reg [1:0] mode_reg;
  reg [7:0] wdog_next;
  reg [1:0] mode_next;
  reg [7:0] busa_next;
  reg [7:0] busb_next;
  reg [7:0] waka_next;
  reg [7:0] wakb_next;
  wire wr_en;
  wire wr_mode;
  wire wr_wdog;
  wire wr_busa;
  wire wr_busb;
  wire wr_waka;
  wire wr_wakb;
  wire soft_cmd;
  wire bank_clear;
  wire parity_odd;
  wire low_power;
  wire any_wake_src;
  wire sleep_blocked;
  wire [1:0] req_mode;
  wire [9:0] stored_modes;
  wire [9:0] active_modes;
  wire [31:0] period_prod;

  assign wr_en = frame_valid && frame_write;
  assign parity_odd = ^frame_data;
  assign req_mode = frame_data[`SBC_MODE_HI:`SBC_MODE_LO];

  // one write strobe per register; the soft-reset code clears the bank like the pin does
  assign wr_mode = wr_en && frame_addr == `SBC_ADDR_MODE;
  assign wr_wdog = wr_en && frame_addr == `SBC_ADDR_WDOG;
  assign wr_busa = wr_en && frame_addr == `SBC_ADDR_BUSA;
  assign wr_busb = wr_en && frame_addr == `SBC_ADDR_BUSB;
  assign wr_waka = wr_en && frame_addr == `SBC_ADDR_WAKA;
  assign wr_wakb = wr_en && frame_addr == `SBC_ADDR_WAKB;
  assign soft_cmd = wr_mode && req_mode == `SBC_MODE_SOFT;
  assign bank_clear = !nrst || soft_reset || soft_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // sleep needs a wake source; transceivers and pin count, with the timer
  assign any_wake_src = waka_reg[`SBC_WA_TIMER] | wakb_reg[`SBC_WB_PIN]
    | (busa_reg[`SBC_BA_CAN_HI:`SBC_BA_CAN_LO] == `SBC_XCV_WAKE)
    | (busa_reg[`SBC_BA_LIN_CH1_MODE_HI:`SBC_BA_LIN_CH1_MODE_LO] == `SBC_XCV_WAKE)
    | (busb_reg[`SBC_BB_LIN_CH2_MODE_HI:`SBC_BB_LIN_CH2_MODE_LO] == `SBC_XCV_WAKE)
    | (busb_reg[`SBC_BB_LIN_CH3_MODE_HI:`SBC_BB_LIN_CH3_MODE_LO] == `SBC_XCV_WAKE)
    | (busb_reg[`SBC_BB_LIN_CH4_MODE_HI:`SBC_BB_LIN_CH4_MODE_LO] == `SBC_XCV_WAKE);
  assign sleep_blocked = wr_en && frame_addr == `SBC_ADDR_MODE
    && req_mode == `SBC_MODE_SLEEP && !any_wake_src;
  assign low_power = (mode_reg == `SBC_MODE_STOP) || (mode_reg == `SBC_MODE_SLEEP);

  ////////////////////////////////////////////////////////////////////////////
  // mode decode; soft reset code is a one-shot, the mode returns to normal
  always @* begin
    mode_next = mode_reg;
    if (wr_en && frame_addr == `SBC_ADDR_MODE) begin
      case (req_mode)
        `SBC_MODE_NORMAL: mode_next = `SBC_MODE_NORMAL;
        `SBC_MODE_SLEEP: mode_next = sleep_blocked ? `SBC_MODE_NORMAL : `SBC_MODE_SLEEP;
        `SBC_MODE_STOP: mode_next = `SBC_MODE_STOP;
        `SBC_MODE_SOFT: mode_next = `SBC_MODE_NORMAL;
        default: mode_next = mode_reg;
      endcase
    end
  end

  // watchdog byte: hardware moves only its own fields, a good host write overrides it
  always @* begin
    wdog_next = wdog_reg;
    if (hw_upd_valid) begin
      wdog_next = (hw_upd_wdog & `SBC_HW_WDOG) | (wdog_reg & ~`SBC_HW_WDOG);
    end
    if (wr_wdog && !parity_odd) begin
      wdog_next = frame_data;
    end
  end

  // bus register a: a host write beats the hardware update of the same cycle
  always @* begin
    busa_next = busa_reg;
    if (wr_busa) begin
      busa_next = frame_data & `SBC_MASK_BUSA;
    end else if (hw_upd_valid) begin
      busa_next = (hw_upd_busa & `SBC_HW_BUSA) | (busa_reg & ~`SBC_HW_BUSA);
    end
  end

  // bus register b: every writable field is a transceiver mode, so hardware may move all
  always @* begin
    busb_next = busb_reg;
    if (wr_busb) begin
      busb_next = frame_data & `SBC_MASK_BUSB;
    end else if (hw_upd_valid) begin
      busb_next = hw_upd_busb & `SBC_HW_BUSB;
    end
  end

  // wake register a: only the second stop-mode watchdog control is hardware owned
  always @* begin
    waka_next = waka_reg;
    if (wr_waka) begin
      waka_next = frame_data & `SBC_MASK_WAKA;
    end else if (hw_upd_valid) begin
      waka_next = (hw_upd_waka & `SBC_HW_WAKA) | (waka_reg & ~`SBC_HW_WAKA);
    end
  end

  // wake source register: host only, the pin enable has no hardware path
  always @* begin
    wakb_next = wakb_reg;
    if (wr_wakb) begin
      wakb_next = frame_data & `SBC_MASK_WAKB;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bank; reserved bits masked on every load
  always @(posedge ref_clk) begin
    if (bank_clear) begin
      wdog_reg <= `SBC_RST_WDOG;
      busa_reg <= `SBC_RST_BUSA;
      busb_reg <= `SBC_RST_BUSB;
      waka_reg <= `SBC_RST_WAKA;
      wakb_reg <= `SBC_RST_WAKB;
      mode_reg <= `SBC_RST_MODE;
    end else begin
      wdog_reg <= wdog_next;
      busa_reg <= busa_next;
      busb_reg <= busb_next;
      waka_reg <= waka_next;
      wakb_reg <= wakb_next;
      mode_reg <= mode_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // spi fail on bad parity of a watchdog write, restart and reset output on refused sleep
  // the fail flag is sticky until the nrst reset; a later good frame does not clear it
  always @(posedge ref_clk) begin
    if (!nrst) begin
      spi_fail <= 1'b0;
      restart_req <= 1'b0;
      reset_out <= 1'b0;
    end else begin
      if (wr_en && frame_addr == `SBC_ADDR_WDOG && parity_odd) begin
        spi_fail <= 1'b1;
      end
      // a one-cycle reset pulse; the external reset stretcher sets its width
      restart_req <= sleep_blocked;
      reset_out <= sleep_blocked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path, registered; unmapped addresses read zero with no hit
  always @(posedge ref_clk) begin
    if (!nrst) begin
      read_data <= 8'h00;
      read_hit <= 1'b0;
    end else if (frame_valid && !frame_write) begin
      read_hit <= 1'b1;
      case (frame_addr)
        `SBC_ADDR_MODE: read_data <= {mode_reg, 6'h00};
        `SBC_ADDR_WDOG: read_data <= wdog_reg;
        `SBC_ADDR_BUSA: read_data <= busa_reg;
        `SBC_ADDR_BUSB: read_data <= busb_reg;
        `SBC_ADDR_WAKA: read_data <= waka_reg;
        `SBC_ADDR_WAKB: read_data <= wakb_reg;
        default: begin
          read_data <= 8'h00;
          read_hit <= 1'b0;
        end
      endcase
    end else begin
      read_hit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded control outputs, all registered
  always @(posedge ref_clk) begin
    if (!nrst) begin
      chip_mode <= `SBC_RST_MODE;
      wdog_stop_off <= 1'b0;
      window_type_sel <= 1'b0;
      wdog_start_on_bus_wake <= 1'b0;
      wdog_max3_limit <= 1'b0;
      wdog_period_sel <= 3'h0;
      lin_slope_off <= 1'b0;
      lin_slope_sel <= 1'b0;
      lin_tx_timeout_en <= 1'b0;
      periodic_timer_wake_en <= 1'b0;
      hv_pin_wake_en <= 1'b0;
    end else begin
      chip_mode <= mode_reg;
      // either stop control switches the watchdog off in stop
      wdog_stop_off <= wdog_reg[`SBC_WD_STOP_OFF] | waka_reg[`SBC_WA_STOP_OFF];
      window_type_sel <= wdog_reg[`SBC_WINDOW_TYPE_SEL];
      wdog_start_on_bus_wake <= wdog_reg[`SBC_WD_BUS_WAKE];
      wdog_max3_limit <= wdog_reg[`SBC_WD_MAX3];
      wdog_period_sel <= wdog_reg[`SBC_WD_PER_HI:`SBC_WD_PER_LO];
      lin_slope_off <= busa_reg[`SBC_BA_FLASH];
      lin_slope_sel <= busa_reg[`SBC_BA_SLOPE];
      lin_tx_timeout_en <= busa_reg[`SBC_BA_TXTO];
      periodic_timer_wake_en <= waka_reg[`SBC_WA_TIMER];
      hv_pin_wake_en <= wakb_reg[`SBC_WB_PIN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // full-width product, cut on purpose where the cycle count is taken
  assign period_prod = wdog_period_ms * `SBC_CLK_KHZ;

  // period decode; reserved codes hold 0 so the timing engine can flag them
  always @(posedge ref_clk) begin
    if (!nrst) begin
      wdog_period_ms <= 16'h0000;
      wdog_period_cycles <= 23'h000000;
    end else begin
      case (wdog_reg[`SBC_WD_PER_HI:`SBC_WD_PER_LO])
        `SBC_PER_10: wdog_period_ms <= `SBC_MS_10;
        `SBC_PER_20: wdog_period_ms <= `SBC_MS_20;
        `SBC_PER_50: wdog_period_ms <= `SBC_MS_50;
        `SBC_PER_100: wdog_period_ms <= `SBC_MS_100;
        `SBC_PER_200: wdog_period_ms <= `SBC_MS_200;
        `SBC_PER_500: wdog_period_ms <= `SBC_MS_500;
        default: wdog_period_ms <= 16'h0000;
      endcase
      // one cycle behind the ms value; 500 ms at 10 MHz needs 23 of the 32 product bits
      wdog_period_cycles <= period_prod[22:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stored mode fields: can, lin_ch1_mode in register a; lin_ch2_mode..lin_ch4_mode in register b
  assign stored_modes = {busb_reg[`SBC_BB_LIN_CH4_MODE_HI:`SBC_BB_LIN_CH4_MODE_LO],
    busb_reg[`SBC_BB_LIN_CH3_MODE_HI:`SBC_BB_LIN_CH3_MODE_LO],
    busb_reg[`SBC_BB_LIN_CH2_MODE_HI:`SBC_BB_LIN_CH2_MODE_LO],
    busa_reg[`SBC_BA_LIN_CH1_MODE_HI:`SBC_BA_LIN_CH1_MODE_LO],
    busa_reg[`SBC_BA_CAN_HI:`SBC_BA_CAN_LO]};

  // one demotion stage per transceiver; receive-only stays receive-only in stop
  genvar gi;
  generate
    for (gi = 0; gi < `SBC_NUM_XCV; gi = gi + 1) begin : g_xcv
      sbc_xcv_mode u_mode (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .stored_mode(stored_modes[2*gi+1:2*gi]),
        .low_power(low_power),
        .active_mode(active_modes[2*gi+1:2*gi])
      );
    end
  endgenerate

  assign can_mode = active_modes[1:0];
  assign lin_ch1_mode = active_modes[3:2];
  assign lin_ch2_mode = active_modes[5:4];
  assign lin_ch3_mode = active_modes[7:6];
  assign lin_ch4_mode = active_modes[9:8];

endmodule // sbc_ctrl_regs
`default_nettype wire

// [sim/sbc_ctrl_monitor.sv]
// checker for the control register group: reads, fail flag, modes, wake enables
// assumes it is bound onto sbc_ctrl_regs and shares its one clock
`timescale 1ns/1ns
`default_nettype none
module sbc_ctrl_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // frame side
  input wire logic frame_valid,
  input wire logic frame_write,
  input wire logic [6:0] frame_addr,
  input wire logic [7:0] frame_data,
  input wire logic [7:0] read_data,
  input wire logic read_hit,
  input wire logic spi_fail,
  // decoded outputs
  input wire logic [1:0] chip_mode,
  input wire logic reset_out,
  input wire logic [2:0] wdog_period_sel,
  input wire logic [15:0] wdog_period_ms,
  input wire logic [1:0] can_mode,
  input wire logic [1:0] lin_ch1_mode,
  input wire logic [1:0] lin_ch2_mode,
  input wire logic [1:0] lin_ch3_mode,
  input wire logic [1:0] lin_ch4_mode,
  input wire logic periodic_timer_wake_en,
  input wire logic hv_pin_wake_en
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // frame kinds, and wake capability as seen at the active modes
  wire logic rd = frame_valid && !frame_write;
  wire logic wr = frame_valid && frame_write;
  wire logic any_norm = can_mode == 2'h3 || lin_ch1_mode == 2'h3 || lin_ch2_mode == 2'h3
    || lin_ch3_mode == 2'h3 || lin_ch4_mode == 2'h3;
  wire logic wake_any = periodic_timer_wake_en || hv_pin_wake_en || can_mode == 2'h1
    || lin_ch1_mode == 2'h1 || lin_ch2_mode == 2'h1 || lin_ch3_mode == 2'h1 || lin_ch4_mode == 2'h1;
  a_read_hit_pulse: assert property (rd && frame_addr == 7'h04 |=> read_hit)
    else $error("mapped read without hit");
  a_unmapped_read_zero: assert property (rd && frame_addr == 7'h10 |=> !read_hit && read_data == 8'h00)
    else $error("unmapped read answered");
  a_odd_parity_fail: assert property (wr && frame_addr == 7'h03 && ^frame_data |=> spi_fail)
    else $error("odd parity write kept flag clear");
  a_fail_flag_sticky: assert property (spi_fail |=> spi_fail)
    else $error("fail flag dropped");
  a_low_power_wake: assert property ((chip_mode != 2'h0) [*3] |-> !any_norm)
    else $error("normal transceiver in low power");
  a_period_500ms: assert property ((wdog_period_sel == 3'h5) [*2] |-> wdog_period_ms == 16'h1f4)
    else $error("period code 5 not 500 ms");
  a_sleep_restart: assert property (wr && frame_addr == 7'h01 && frame_data[7:6] == 2'h1 && !wake_any
    |-> ##[1:3] reset_out)
    else $error("sleep without wake source no reset");
  a_pin_wake_follows: assert property (wr && frame_addr == 7'h07
    |-> ##2 hv_pin_wake_en == $past(frame_data[0], 2))
    else $error("pin wake enable wrong");
  a_timer_wake_follows: assert property (wr && frame_addr == 7'h06
    |-> ##2 periodic_timer_wake_en == $past(frame_data[6], 2))
    else $error("timer wake enable wrong");
  c_restart: cover property (reset_out);
  c_stop_mode: cover property (chip_mode == 2'h2);
  c_parity_fail: cover property ($rose(spi_fail));
endmodule // sbc_ctrl_monitor

bind sbc_ctrl_regs sbc_ctrl_monitor sbc_ctrl_monitor_i (.*);
`default_nettype wire

// [sim/sbc_host.sv]
// host model: the spi master side, one decoded frame at a time
// assumes frames launch from the falling edge of ref_clk
`timescale 1ns/1ns
`default_nettype none
module sbc_host (
  // clock
  input wire logic ref_clk,
  // frame towards the device
  output logic frame_valid,
  output logic frame_write,
  output logic [6:0] frame_addr,
  output logic [7:0] frame_data,
  // read answer
  input wire logic [7:0] read_data,
  input wire logic read_hit
);
  ////////////////////////////////////////////////////////////////////////////////
  // idle lines carry junk so nothing relies on them
  initial begin
    frame_valid = 1'b0;
    frame_write = 1'b0;
    frame_addr = 7'h55;
    frame_data = 8'haa;
  end
  // taken at the next rising edge; answer sampled mid-cycle after it
  task automatic frame(input logic w, input logic [6:0] ad, input logic [7:0] d, output logic [7:0] rq,
    output logic rh);
    @(negedge ref_clk);
    frame_valid = 1'b1;
    frame_write = w;
    frame_addr = ad;
    frame_data = d;
    @(negedge ref_clk);
    frame_valid = 1'b0;
    frame_addr = ~ad;
    frame_data = ~d;
    rq = read_data;
    rh = read_hit;
  endtask
endmodule // sbc_host
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench: register model in arrays, compared after every read frame
// assumes the register group, host model and bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // stimulus and model state
  logic ref_clk, nrst, soft_reset, hw_upd_valid, fail_exp, h;
  logic [1:0] cm;
  logic [6:0] a;
  logic [7:0] q, hw_upd_wdog, hw_upd_busa, hw_upd_busb, hw_upd_waka;
  logic [7:0] m [1:7];
  logic [7:0] mk [1:7];
  logic [15:0] ms_tab [0:7];
  int fail_count, total_checks, i;
  // design outputs
  wire frame_valid, frame_write, read_hit, spi_fail, restart_req, reset_out, wdog_stop_off;
  wire window_type_sel, wdog_start_on_bus_wake, wdog_max3_limit, lin_slope_off, lin_slope_sel;
  wire lin_tx_timeout_en, periodic_timer_wake_en, hv_pin_wake_en;
  wire [1:0] chip_mode, can_mode, lin_ch1_mode, lin_ch2_mode, lin_ch3_mode, lin_ch4_mode;
  wire [2:0] wdog_period_sel;
  wire [6:0] frame_addr;
  wire [7:0] frame_data, read_data;
  wire [15:0] wdog_period_ms;
  wire [22:0] wdog_period_cycles;
  // grouped views for short compares
  wire [3:0] wd_ctl = {wdog_stop_off, window_type_sel, wdog_start_on_bus_wake, wdog_max3_limit};
  wire [2:0] lin_ctl = {lin_slope_off, lin_slope_sel, lin_tx_timeout_en};
  wire [9:0] xcv = {lin_ch4_mode, lin_ch3_mode, lin_ch2_mode, lin_ch1_mode, can_mode};
  wire [1:0] wk = {periodic_timer_wake_en, hv_pin_wake_en};
  sbc_ctrl_regs sbc_ctrl_regs_i (.*);
  sbc_host sbc_host_i (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // hang guard: some thirty times the expected run
  initial begin
    #2000000;
    fail_count++;
    wrap_up;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [22:0] e, input logic [22:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // normal code runs wake capable while in stop or sleep
  function automatic logic [1:0] act(input logic [1:0] s);
    return (cm != 2'h0 && s == 2'h3) ? 2'h1 : s;
  endfunction
  task automatic defaults;
    m = '{8'h00, 8'h00, 8'h14, 8'h20, 8'h00, 8'h00, 8'h01};
    cm = 2'h0;
  endtask
  task automatic rd(input logic [6:0] ad, input logic [7:0] e, input logic eh);
    sbc_host_i.frame(1'b0, ad, 8'h00, q, h);
    chk("read_data", e, q);
    chk("read_hit", eh, h);
  endtask
  // the five settle cycles cover the slowest derived output
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    sbc_host_i.frame(1'b1, ad, d, q, h);
    if (ad == 7'h01)
      cm = d[7:6];
    else if (ad == 7'h03 && ^d)
      fail_exp = 1'b1;
    else if (ad > 7'h02 && ad < 7'h08)
      m[ad] = d & mk[ad];
    repeat (5) @(negedge ref_clk);
  endtask
  task automatic rd_all;
    for (a = 7'h03; a < 7'h08; a++)
      rd(a, m[a], 1'b1);
    rd(7'h10, 8'h00, 1'b0);
    rd(7'h01, {cm, 6'h00}, 1'b1);
  endtask
  task automatic chk_out;
    chk("spi_fail", fail_exp, spi_fail);
    chk("chip_mode", cm, chip_mode);
    chk("pulses", 2'h0, {restart_req, reset_out});
    chk("wdog_ctl", {m[3][6] | m[6][2], m[3][5:3]}, wd_ctl);
    chk("period_sel", m[3][2:0], wdog_period_sel);
    chk("period_ms", ms_tab[m[3][2:0]], wdog_period_ms);
    chk("period_cyc", 23'(ms_tab[m[3][2:0]]) * 23'h2710, wdog_period_cycles);
    chk("lin_ctl", m[4][7:5], lin_ctl);
    chk("busb_modes", {act(m[5][7:6]), act(m[5][4:3]), act(m[5][1:0])}, xcv[9:4]);
    chk("busa_modes", {act(m[4][4:3]), act(m[4][1:0])}, xcv[3:0]);
    chk("wake_en", {m[6][6], m[7][0]}, wk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    nrst = 1'b0;
    soft_reset = 1'b0;
    hw_upd_valid = 1'b0;
    {hw_upd_wdog, hw_upd_busa, hw_upd_busb, hw_upd_waka} = 32'h0;
    fail_exp = 1'b0;
    fail_count = 0;
    total_checks = 0;
    mk = '{8'h00, 8'h00, 8'hff, 8'hfb, 8'hdb, 8'h44, 8'h01};
    ms_tab = '{16'ha, 16'h14, 16'h32, 16'h64, 16'hc8, 16'h1f4, 16'h0, 16'h0};
    defaults;
    void'($urandom(32'ha553));
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (5) @(negedge ref_clk);
    rd_all;
    chk_out;
    // random traffic, odd parity included
    repeat (40) begin
      a = 7'h03 + 7'($urandom % 5);
      wr(a, 8'($urandom));
      chk_out;
      rd(a, m[a], 1'b1);
    end
    for (i = 0; i < 8; i++) begin
      wr(7'h03, {^3'(i), 4'h0, 3'(i)});
      chk_out;
    end
    // hardware update with random bytes; only the hardware-owned fields may move
    hw_upd_wdog = 8'($urandom);
    hw_upd_busa = 8'($urandom);
    hw_upd_busb = 8'($urandom);
    hw_upd_waka = 8'($urandom);
    hw_upd_valid = 1'b1;
    @(negedge ref_clk);
    hw_upd_valid = 1'b0;
    m[3] = (hw_upd_wdog & 8'h57) | (m[3] & 8'ha8);
    m[4] = (hw_upd_busa & 8'h1b) | (m[4] & 8'he0);
    m[5] = hw_upd_busb & 8'hdb;
    m[6] = (hw_upd_waka & 8'h04) | (m[6] & 8'h40);
    repeat (5) @(negedge ref_clk);
    chk_out;
    rd_all;
    // stop, receive-only chosen beforehand, then back to normal
    wr(7'h04, 8'h1b);
    wr(7'h05, 8'h9a);
    wr(7'h01, 8'h80);
    chk_out;
    rd_all;
    wr(7'h01, 8'h00);
    chk_out;
    // sleep with a wake source
    wr(7'h07, 8'h01);
    wr(7'h04, {m[4][7:2], 2'h1});
    wr(7'h01, 8'h40);
    chk_out;
    wr(7'h01, 8'h00);
    // sleep with no wake source falls back to restart
    for (a = 7'h04; a < 7'h08; a++)
      wr(a, 8'h00);
    sbc_host_i.frame(1'b1, 7'h01, 8'h40, q, h);
    h = 1'b0;
    for (i = 0; i < 4; i++) begin
      h = h | (reset_out & restart_req);
      @(negedge ref_clk);
    end
    chk("restart", 1'b1, h);
    chk_out;
    // soft reset by mode code, then by pin
    for (i = 0; i < 2; i++) begin
      wr(7'h07, 8'h00);
      if (i == 0) begin
        wr(7'h01, 8'hc0);
      end else begin
        soft_reset = 1'b1;
        @(negedge ref_clk);
        soft_reset = 1'b0;
        repeat (5) @(negedge ref_clk);
      end
      defaults;
      chk_out;
      rd_all;
    end
    // a bad checksum on a watchdog write raises the fail flag; a hard reset in mid-run clears it
    wr(7'h03, 8'h01);
    chk_out;
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (5) @(negedge ref_clk);
    fail_exp = 1'b0;
    chk_out;
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
